/* rcs_pkg.sv */
// Package for the reset control sequencer: cause flag layout, counts, sequence states.
// Assumes a single 250 MHz system clock and a power-on detector as master reset.
package rcs_pkg;

    // ****************************************************************
    // Cause flag positions
    // ****************************************************************
    localparam int          RCS_NCAUSE    = 5;
    localparam int          RCS_EXT_BIT   = 0;
    localparam int          RCS_POR_BIT   = 1;
    localparam int          RCS_BOR_BIT   = 2;
    localparam int          RCS_SW_BIT    = 3;
    localparam int          RCS_WDT_BIT   = 4;
    localparam logic [4:0]  RCS_CAUSE_RST = 5'h02;
    localparam int          RCS_NPERIPH   = 32;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int          RCS_CLK_MHZ      = 250;
    localparam int          RCS_HOLD_NS      = 20;
    localparam int          RCS_HOLD_CYC     = (RCS_HOLD_NS * RCS_CLK_MHZ + 999) / 1000;
    localparam logic [3:0]  RCS_HOLD_CYC_W   = 4'(RCS_HOLD_CYC);
    localparam logic [3:0]  RCS_CNT_ZERO     = 4'h0;
    localparam logic [3:0]  RCS_CNT_ONE      = 4'h1;

    // ****************************************************************
    // Identification defaults, values arbitrary
    // ****************************************************************
    localparam logic [31:0] RCS_IDENT0_DEF = 32'h0001_0000;
    localparam logic [31:0] RCS_IDENT1_DEF = 32'h1000_0001;
    localparam logic [31:0] RCS_CAP_DEF    = 32'h0000_0000;

    // ****************************************************************
    // Core release sequence
    // ****************************************************************
    typedef enum logic [2:0] {
        RCS_HOLD,
        RCS_FETCH_SP,
        RCS_FETCH_PC,
        RCS_FETCH_INSN,
        RCS_RUN
    } rcs_seq_e;

endpackage

/* rcs_sync_if.sv */
// Interface carrying raw reset requests into the synchroniser and clean levels back.
// Assumes the requests are asynchronous to ref_clk.
`timescale 1ns/100ps
interface rcs_sync_if;
    logic [3:0] raw;
    logic [3:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface

/* rcs_sync.sv */
// Two-flop synchroniser for the asynchronous reset requests.
// Assumes ref_clk and the power-on master reset.
`timescale 1ns/100ps
module rcs_sync
(
    input  wire logic   ref_clk,
    input  wire logic   arst_n,
    rcs_sync_if.sync    sif
);
    logic [3:0] meta_r;
    logic [3:0] clean_r;

    // First stage feeds only the second stage to keep metastability contained.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_r  <= 4'h0;
            clean_r <= 4'h0;
        end
        else
        begin
            meta_r  <= sif.raw;
            clean_r <= meta_r;
        end
    end

    assign sif.clean = clean_r;
endmodule

/* rcs_top.sv */
// Reset control sequencer: merges reset sources, records causes, sequences core release.
// Assumes arst_n is the power-on detector output and all other requests may be asynchronous.
`timescale 1ns/100ps

module rcs_top
    import rcs_pkg::*;
(
    input  wire logic                          ref_clk,
    input  wire logic                          arst_n,
    input  wire logic                          ext_rst_n,
    input  wire logic                          brownout_detect,
    input  wire logic                          brownout_reset_enable,
    input  wire logic                          system_reset_request,
    input  wire logic                          wdt_second_timeout,
    input  wire logic                          wdt_reset_enable,
    input  wire logic [rcs_pkg::RCS_NPERIPH-1:0] peripheral_soft_reset_regs,
    output logic                               sys_rst_n,
    output logic                               tap_rst_n,
    output logic [rcs_pkg::RCS_NPERIPH-1:0]    periph_rst_n,
    output logic [rcs_pkg::RCS_NCAUSE-1:0]     reset_cause_flags,
    output logic                               core_fetch_sp,
    output logic                               core_fetch_pc,
    output logic                               core_fetch_insn,
    output logic                               core_running,
    output logic [31:0]                        device_ident_word0,
    output logic [31:0]                        device_ident_word1,
    output logic [31:0]                        device_capability_words
);
    import rcs_pkg::*;

    // ****************************************************************
    // Synchronised requests
    // ****************************************************************
    rcs_sync_if sif ();
    logic ext_req;
    logic bor_req;
    logic sw_req;
    logic wdt_req;

    // Requests are gated with their enables before synchronising.
    assign sif.raw = {wdt_second_timeout & wdt_reset_enable,
                      system_reset_request,
                      brownout_detect & brownout_reset_enable,
                      ~ext_rst_n};
    assign ext_req = sif.clean[0];
    assign bor_req = sif.clean[1];
    assign sw_req  = sif.clean[2];
    assign wdt_req = sif.clean[3];

    rcs_sync u_rcs_sync
    (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .sif     (sif)
    );

    // ****************************************************************
    // Reset hold and sequence
    // ****************************************************************
    logic       any_req;
    logic [3:0] hold_r;
    logic [3:0] hold_nxt;
    rcs_seq_e   seq_r;
    rcs_seq_e   seq_nxt;
    logic       in_reset;

    // A software request is a pulse; hold stretches it to a whole reset.
    assign any_req  = ext_req | bor_req | sw_req | wdt_req;
    assign hold_nxt = any_req ? RCS_HOLD_CYC_W :
                      (hold_r != RCS_CNT_ZERO) ? hold_r - RCS_CNT_ONE : hold_r;
    assign in_reset = (seq_r == RCS_HOLD);

    // Release waits for all requests to clear and the hold count to run out.
    always_comb
    begin
        seq_nxt = seq_r;
        case (seq_r)
            RCS_HOLD:       seq_nxt = (!any_req && hold_r == RCS_CNT_ZERO)
                                      ? RCS_FETCH_SP : RCS_HOLD;
            RCS_FETCH_SP:   seq_nxt = RCS_FETCH_PC;
            RCS_FETCH_PC:   seq_nxt = RCS_FETCH_INSN;
            RCS_FETCH_INSN: seq_nxt = RCS_RUN;
            RCS_RUN:        seq_nxt = RCS_RUN;
            default:        seq_nxt = RCS_HOLD;
        endcase
        if (any_req)
            seq_nxt = RCS_HOLD;
    end

    // Power-on resets everything; arst_n is only low at power-up.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            seq_r  <= RCS_HOLD;
            hold_r <= RCS_HOLD_CYC_W;
        end
        else
        begin
            seq_r  <= seq_nxt;
            hold_r <= hold_nxt;
        end
    end

    assign sys_rst_n       = !in_reset;
    assign tap_rst_n       = arst_n;
    assign core_fetch_sp   = (seq_r == RCS_FETCH_SP);
    assign core_fetch_pc   = (seq_r == RCS_FETCH_PC);
    assign core_fetch_insn = (seq_r == RCS_FETCH_INSN);
    assign core_running    = (seq_r == RCS_RUN);

    // ****************************************************************
    // Cause flags
    // ****************************************************************
    logic [RCS_NCAUSE-1:0] cause_r;
    logic [RCS_NCAUSE-1:0] cause_nxt;

    logic [RCS_NCAUSE-1:0] req_now;
    logic [RCS_NCAUSE-1:0] req_d_r;
    logic [RCS_NCAUSE-1:0] req_seen;

    // A one-cycle request has gone by the time reset is entered; the delayed copy keeps it.
    assign req_now  = {wdt_req, sw_req, bor_req, 1'b0, ext_req};
    assign req_seen = req_now | req_d_r;

    // Flags only accumulate while reset is held, so software sees a stable value.
    always_comb
    begin
        cause_nxt = cause_r;
        if (in_reset)
            cause_nxt = cause_r | req_seen;
    end

    // Power-on leaves only its own flag.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cause_r <= RCS_CAUSE_RST;
            req_d_r <= '0;
        end
        else
        begin
            cause_r <= cause_nxt;
            req_d_r <= req_now;
        end
    end

    assign reset_cause_flags = cause_r;

    // ****************************************************************
    // Peripheral soft resets
    // ****************************************************************
    logic [RCS_NPERIPH-1:0] soft_prev_r;
    logic [RCS_NPERIPH-1:0] periph_rst_r;
    logic [RCS_NPERIPH-1:0] periph_fall;

    // Reset fires on the clear that follows a set.
    assign periph_fall = soft_prev_r & ~peripheral_soft_reset_regs;

    // Peripherals sit in reset for the whole power-on pulse as well.
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            soft_prev_r  <= '0;
            periph_rst_r <= '1;
        end
        else
        begin
            soft_prev_r  <= peripheral_soft_reset_regs;
            periph_rst_r <= periph_fall | {RCS_NPERIPH{in_reset}};
        end
    end

    assign periph_rst_n = ~periph_rst_r;

    // ****************************************************************
    // Identification, constant so writes cannot alter them
    // ****************************************************************
    assign device_ident_word0      = RCS_IDENT0_DEF;
    assign device_ident_word1      = RCS_IDENT1_DEF;
    assign device_capability_words = RCS_CAP_DEF;

    // ****************************************************************
    // Checks
    // ****************************************************************
    logic [2:0] run_gap_r;
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            run_gap_r <= 3'h0;
        else
            run_gap_r <= {run_gap_r[1:0], core_fetch_sp};
    end

    hold_on_req_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        any_req |=> !sys_rst_n) else $error("reset not asserted on request");
    cause_sticky_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (cause_r & ~$past(cause_r)) == '0 || $past(in_reset))
        else $error("cause flags changed outside reset");
    flag_kept_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ($past(cause_r) & ~cause_r) == '0) else $error("cause flag lost");
    ext_flag_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        in_reset && ext_req |=> cause_r[RCS_EXT_BIT]) else $error("pin cause missing");
    fetch_order_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        core_fetch_sp && !any_req ##1 !any_req |-> core_fetch_pc ##1 core_fetch_insn)
        else $error("fetch order wrong");
    bor_gate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !brownout_reset_enable && !ext_rst_n == 1'b0 && !system_reset_request
        && !wdt_second_timeout [*3] |=> !bor_req) else $error("brown-out not gated");
    wdt_gate_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !wdt_reset_enable [*3] |-> !wdt_req) else $error("watchdog not gated");
    soft_pulse_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        (($past(peripheral_soft_reset_regs) & ~peripheral_soft_reset_regs) != '0)
        |=> ((periph_rst_n & $past(peripheral_soft_reset_regs, 2)
              & ~$past(peripheral_soft_reset_regs)) == '0))
        else $error("peripheral soft reset missing");
    hold_time_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        $fell(any_req) |-> !sys_rst_n [*5]) else $error("hold too short");
    tap_kept_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        ext_req |-> tap_rst_n) else $error("tap reset by pin");
endmodule

/* rcs_pin_model.sv */
// Board reset circuitry in front of the reset pin: a switch stretched by an RC network.
// Assumes press is driven on ref_clk rising edges by the bench.
`timescale 1ns/100ps
module rcs_pin_model
#(
    parameter int MIN_LOW = 5
)
(
    input  wire logic ref_clk,
    input  wire logic press,
    output logic      ext_rst_n
);
    logic [3:0] low_cnt_r;

    // ****************************************************************
    // Pin drive
    // ****************************************************************
    initial
    begin
        ext_rst_n = 1'b1;
        low_cnt_r = 4'h0;
    end

    // A short press is stretched so the pin never stays low under its minimum.
    always @(posedge ref_clk)
    begin
        if (press)
        begin
            ext_rst_n <= 1'b0;
            low_cnt_r <= 4'(MIN_LOW);
        end
        else if (low_cnt_r != 4'h0)
            low_cnt_r <= low_cnt_r - 4'h1;
        else
            ext_rst_n <= 1'b1; // The pull-up takes the released pin high.
    end
endmodule

/* rcs_top_tb_top.sv */
// Self-checking bench for the reset control sequencer.
// Assumes one 250 MHz clock; the pin is driven through the board model.
`timescale 1ns/100ps
module rcs_top_tb_top;
    import rcs_pkg::*;
    logic ref_clk = 1'b0, arst_n = 1'b0, press = 1'b0, ext_rst_n, bod = 1'b0;
    logic bod_en = 1'b0, sreq = 1'b0, wdt_to = 1'b0, wdt_en = 1'b0;
    logic [31:0] soft_r = 32'h0000_0000;
    logic sys_rst_n, tap_rst_n, f_sp, f_pc, f_insn, core_running;
    logic [31:0] periph_rst_n, id0, id1, cap;
    logic [4:0] cause;
    logic [4:0] exp_q[$];
    int errors = 0, checks_done = 0, k, hits;

    // ****************************************************************
    // Clock, partner and design
    // ****************************************************************
    always #2 ref_clk = ~ref_clk;
    rcs_pin_model u_rcs_pin_model (.ref_clk(ref_clk), .press(press), .ext_rst_n(ext_rst_n));
    rcs_top u_rcs_top (.ref_clk(ref_clk), .arst_n(arst_n), .ext_rst_n(ext_rst_n),
        .brownout_detect(bod), .brownout_reset_enable(bod_en), .system_reset_request(sreq),
        .wdt_second_timeout(wdt_to), .wdt_reset_enable(wdt_en),
        .peripheral_soft_reset_regs(soft_r), .sys_rst_n(sys_rst_n), .tap_rst_n(tap_rst_n),
        .periph_rst_n(periph_rst_n), .reset_cause_flags(cause), .core_fetch_sp(f_sp),
        .core_fetch_pc(f_pc), .core_fetch_insn(f_insn), .core_running(core_running),
        .device_ident_word0(id0), .device_ident_word1(id1), .device_capability_words(cap));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Bounded wait for the core to run again; a hang ends the run.
    task automatic wait_run();
        int n;
        n = 0;
        while (core_running !== 1'b1 && n < 300)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (core_running !== 1'b1)
        begin
            errors++;
            $display("[FAIL] %0t core never ran", $time);
            give_verdict();
        end
    endtask

    // Raise one source for len cycles, noting the cause flags expected at release.
    task automatic run_reset(input int which, input int len, input logic [4:0] exp);
        exp_q.push_back(exp);
        @(posedge ref_clk);
        press <= (which == 0);
        bod <= (which == 1);
        sreq <= (which == 2);
        wdt_to <= (which == 3);
        repeat (len) @(posedge ref_clk);
        check(sys_rst_n, 1'b0);
        check(tap_rst_n, 1'b1);
        {press, bod, sreq, wdt_to} <= 4'h0;
        @(posedge ref_clk);
        @(posedge ref_clk);
        check(sys_rst_n, 1'b0);
        check(periph_rst_n, 32'h0000_0000);
        wait_run();
    endtask

    // A source whose enable is off must leave the core running.
    task automatic ignored(input int which);
        @(posedge ref_clk);
        bod <= (which == 1);
        wdt_to <= (which == 3);
        repeat (20) @(posedge ref_clk);
        check(sys_rst_n, 1'b1);
        check(cause, 5'h02);
        {bod, wdt_to} <= 2'b00;
    endtask

    // ****************************************************************
    // Monitor: each release takes the oldest note and checks the order
    // ****************************************************************
    always
    begin
        @(posedge ref_clk);
        if (f_sp === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(32'h0000_0001, 32'h0000_0000);
            else
                check(cause, exp_q.pop_front());
            check(sys_rst_n, 1'b1);
            @(posedge ref_clk);
            check({f_sp, f_pc, f_insn, core_running}, 4'h4);
            @(posedge ref_clk);
            check({f_sp, f_pc, f_insn, core_running}, 4'h2);
            @(posedge ref_clk);
            check({f_pc, f_insn, core_running}, 3'h1);
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial
    begin
        void'($urandom(79));
        exp_q.push_back(5'h02);
        repeat (10) @(posedge ref_clk);
        check({sys_rst_n, tap_rst_n}, 2'b00);
        check(periph_rst_n, 32'h0000_0000);
        arst_n <= 1'b1;
        wait_run();
        check(id0, RCS_IDENT0_DEF);
        check(id1, RCS_IDENT1_DEF);
        check(cap, RCS_CAP_DEF);
        ignored(1);
        ignored(3);
        run_reset(0, 5 + $urandom % 5, 5'h03);
        bod_en <= 1'b1;
        run_reset(1, 5 + $urandom % 20, 5'h07);
        run_reset(2, 4, 5'h0F);
        wdt_en <= 1'b1;
        run_reset(3, 4, 5'h1F);
        k = $urandom % 32;
        hits = 0;
        soft_r[k] <= 1'b1;
        @(posedge ref_clk);
        soft_r[k] <= 1'b0;
        repeat (5)
        begin
            @(posedge ref_clk);
            hits += (periph_rst_n[k] === 1'b0);
        end
        check(hits, 1);
        check(sys_rst_n, 1'b1);
        exp_q.push_back(5'h02);
        arst_n <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check(tap_rst_n, 1'b0);
        arst_n <= 1'b1;
        wait_run();
        repeat (5) @(posedge ref_clk);
        check(exp_q.size(), 0);
        give_verdict();
    end
endmodule
